// ==== verilog/zcd_pkg.sv ====
package zcd_pkg;
   // Pressure words are signed, in units of 1/10000 of full range
   localparam int P_W = 24;
   localparam logic signed [23:0] FULL_RANGE = 24'sh002710;    // 100 % of full range
   localparam logic signed [23:0] OVER_LIMIT = 24'sh002af8;    // 110 % of full range
   localparam logic signed [23:0] STEP_LIMIT = 24'sh0003e8;    // 10 % per zero step
   localparam logic signed [23:0] ACC_LIMIT = 24'sh0007d0;     // 20 % accumulated
   localparam logic signed [23:0] NULL_LIMIT = 24'sh0007d0;    // 20 % in plain nulling
   localparam logic signed [23:0] TRIM_LIMIT = 24'sh0001f4;    // 5 % in offset/target modes
   // Analog code for 10 V at 100 % of full range
   localparam logic [15:0] DAC_FULL = 16'hfa00;
   // Timing
   localparam longint CLK_HZ = 250000000;
   localparam longint WARM_S = 300;                            // 5 minute power-up wait
   localparam longint HOLD_MS = 2000;                          // 2 second button hold
   localparam longint WARM_CYC = WARM_S * CLK_HZ;
   localparam longint HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   localparam longint SEC_CYC = CLK_HZ;                        // On-time tick per second
   // Zero modes
   typedef enum logic [1:0] {
      ZCD_NULL = 2'b00,
      ZCD_OFFSET = 2'b01,
      ZCD_TARGET = 2'b10
   } zcd_mode_t;
endpackage : zcd_pkg

// ==== verilog/zcd_trig_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Zero trigger handshake between the button timer and the zero engine
interface zcd_trig_if;
   logic fire;      // One-cycle zero request
   modport src (output fire);
   modport dst (input fire);
endinterface : zcd_trig_if
`default_nettype wire

// ==== verilog/zcd_button.sv ====
`timescale 1ns/1ns
`default_nettype none
module zcd_button import zcd_pkg::*; #(
   parameter longint HOLD_CYCLES = HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic button_pin,
   zcd_trig_if.src trig
);
   initial begin
      if (HOLD_CYCLES < 1) $error("hold count must be positive");
   end
   logic [2:0] sync_r;        // Three-stage pin synchroniser
   logic btn_r;               // Accepted button level
   logic [39:0] hold_r;       // Hold timer
   logic done_r;              // Zero already issued for this press

   // Synchroniser; a change counts once stages two and three agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync_r <= 3'h0;
         btn_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], button_pin};
         if (sync_r[1] == sync_r[2]) begin
            btn_r <= sync_r[2];
         end
      end
   end

   // Hold timer restarts on release; one pulse per qualifying press
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hold_r <= 40'h0;
         done_r <= 1'b0;
      end else if (!btn_r) begin
         hold_r <= 40'h0;
         done_r <= 1'b0;
      end else if (!done_r) begin
         if (hold_r == 40'(HOLD_CYCLES - 1)) begin
            done_r <= 1'b1;
         end
         hold_r <= hold_r + 40'h1;
      end
   end

   assign trig.fire = btn_r && !done_r && (hold_r == 40'(HOLD_CYCLES - 1));
endmodule : zcd_button
`default_nettype wire

// ==== verilog/zcd_top.sv ====
// Functional notes
// - No zero before temperature ready and five minutes
// - Button must be held two seconds
// - Step under 10%, accumulated under 20%
// - Standby status clears at control temperature
// - Button and remote zero act identically
// - Three modes, correction on analog and digital
// - Nulling reads zero, limited to 20%
// - Nulling target defaults to zero
// - Offset mode sets fraction, limit 5%
// - Target mode reads fraction at vacuum, 5%
// - Offset/target set only over network
// - Analog scale: full range gives 10 V
// - Powered-on time counter never user-cleared
// - Cumulative drift never user-cleared
// - Count over-range above 110%
// - Count diaphragm-short exposures
// - Track max/min with on-time stamp
// - Extremes clear restarts tracking next sample
// - Limit crossing raises alarm, amber indicator
// - Refresh rate zero stops automatic updates
`timescale 1ns/1ns
`default_nettype none
module zcd_top import zcd_pkg::*; #(
   parameter longint WARM_CYCLES = WARM_CYC,    // Power-up wait, shorten in simulation
   parameter longint HOLD_CYCLES = HOLD_CYC,    // Button hold, shorten in simulation
   parameter longint SEC_CYCLES = SEC_CYC,      // On-time tick period
   parameter int CNT_W = 32                     // Width of diagnostic counters
) (
   input wire logic ref_clk,
   input wire logic rst,
   // Sensor side
   input wire logic signed [23:0] raw_pressure,  // Uncorrected pressure sample
   input wire logic sample_valid,                // One-cycle sample strobe
   input wire logic temp_ready_pin,              // Sensor at control temperature
   input wire logic diaphragm_short_pin,         // Diaphragm shorted
   // Operator and network side
   input wire logic button_pin,                  // Local zero push-button, high when pressed
   input wire logic remote_zero,                 // Network zero command pulse
   input wire logic net_cfg_write,               // Network configuration write pulse
   input wire logic [1:0] net_mode,              // Mode to apply
   input wire logic signed [23:0] net_fraction,  // Offset/target fraction value
   input wire logic signed [23:0] upper_limit,   // Alarm upper limit
   input wire logic signed [23:0] lower_limit,   // Alarm lower limit
   input wire logic extremes_clear,              // Clear min/max pulse
   input wire logic [15:0] refresh_rate,         // Display refresh period in seconds, 0 is off
   input wire logic manual_refresh,              // Manual display refresh pulse
   // Outputs
   output logic signed [23:0] digital_pressure,  // Corrected pressure
   output logic [15:0] analog_code,              // Analog output code
   output logic standby,                         // Standby status indication
   output logic zero_enabled,                    // Zero actions allowed
   output logic zero_done,                       // Zero applied, one cycle
   output logic zero_rejected,                   // Zero refused, one cycle
   output logic [1:0] active_mode,               // Mode in force
   output logic signed [23:0] zero_correction,   // Correction in force
   output logic signed [31:0] drift_total,       // Cumulative drift
   output logic [31:0] on_time,                  // Powered-on seconds
   output logic [CNT_W-1:0] over_range_count,    // Over-range excursions
   output logic [CNT_W-1:0] short_count,         // Diaphragm-short excursions
   output logic signed [23:0] pressure_max,      // Highest pressure
   output logic [31:0] max_time,                 // On-time of maximum
   output logic signed [23:0] pressure_min,      // Lowest pressure
   output logic [31:0] min_time,                 // On-time of minimum
   output logic alarm,                           // Limit alarm
   output logic led_amber,                       // Status indicator amber
   output logic display_update                   // Display refresh pulse
);
   initial begin
      if (WARM_CYCLES < 1 || SEC_CYCLES < 1) $error("timing counts must be positive");
      if (CNT_W < 1) $error("counter width must be positive");
   end

   zcd_trig_if trig ();
   zcd_button #(.HOLD_CYCLES(HOLD_CYCLES)) u_button (
      .ref_clk(ref_clk),
      .rst(rst),
      .button_pin(button_pin),
      .trig(trig)
   );

   logic [2:0] temp_s_r;          // Temperature flag synchroniser
   logic temp_r;                  // Accepted temperature flag
   logic [2:0] short_s_r;         // Short flag synchroniser
   logic short_r;                 // Accepted short flag
   logic short_d_r;               // Previous short level for edge
   logic [39:0] warm_r;           // Power-up timer
   logic warm_done_r;             // Power-up timer expired
   logic [1:0] mode_r;            // Configured mode
   logic signed [23:0] frac_r;    // Configured fraction
   logic signed [23:0] corr_r;    // Correction added to raw pressure
   logic signed [31:0] drift_r;   // Accumulated drift magnitude
   logic signed [23:0] last_raw_r;// Latest raw sample
   logic signed [23:0] corr_nxt;  // Proposed correction
   logic signed [23:0] step;      // Change asked for
   logic signed [23:0] dev;       // Proposed deviation from factory zero
   logic signed [23:0] mode_lim;  // Limit of this mode
   logic accept;                  // Proposed zero passes all checks
   logic req;                     // Zero request from either source
   logic signed [23:0] corrected; // Corrected sample
   logic [39:0] sec_r;            // Second prescaler
   logic [31:0] on_r;             // Powered-on seconds
   logic over_d_r;                // Previous over-range state
   logic ext_valid_r;             // Extremes hold a sample
   logic [15:0] ref_cnt_r;        // Display seconds counter
   logic tick;                    // One-second tick

   // Pin synchronisers; a change counts when stages two and three agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         temp_s_r <= 3'h0;
         temp_r <= 1'b0;
         short_s_r <= 3'h0;
         short_r <= 1'b0;
      end else begin
         temp_s_r <= {temp_s_r[1:0], temp_ready_pin};
         short_s_r <= {short_s_r[1:0], diaphragm_short_pin};
         if (temp_s_r[1] == temp_s_r[2]) begin
            temp_r <= temp_s_r[2];
         end
         if (short_s_r[1] == short_s_r[2]) begin
            short_r <= short_s_r[2];
         end
      end
   end

   // Standby message drops once the sensor is at temperature
   assign standby = !temp_r;

   // Power-up timer runs once per power cycle
   // Forty bits hold the full five-minute count at the system clock rate
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         warm_r <= 40'h0;
         warm_done_r <= 1'b0;
      end else if (!warm_done_r) begin
         if (warm_r == 40'(WARM_CYCLES - 1)) begin
            warm_done_r <= 1'b1;
         end
         warm_r <= warm_r + 40'h1;
      end
   end

   // Both gates must be met before any zero is taken
   assign zero_enabled = temp_r && warm_done_r;

   // Mode and fraction come only from the network port
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_r <= ZCD_NULL;
         frac_r <= 24'sh0;
      end else if (net_cfg_write) begin
         mode_r <= (net_mode == ZCD_OFFSET || net_mode == ZCD_TARGET) ? net_mode : ZCD_NULL;
         frac_r <= net_fraction;
      end
   end
   assign active_mode = mode_r;

   // Latest raw sample, used as the reference for the next zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         last_raw_r <= 24'sh0;
      end else if (sample_valid) begin
         last_raw_r <= raw_pressure;
      end
   end

   // Either source fires the same request
   assign req = trig.fire || remote_zero;

   // Proposed correction: output must read the target at this pressure.
   // Nulling targets zero; offset and target both read the fraction.
   always_comb begin
      corr_nxt = 24'sh0;
      mode_lim = NULL_LIMIT;
      case (mode_r)
         ZCD_NULL: begin
            corr_nxt = -last_raw_r;
            mode_lim = NULL_LIMIT;
         end
         ZCD_OFFSET: begin
            corr_nxt = frac_r - last_raw_r;
            mode_lim = TRIM_LIMIT;
         end
         ZCD_TARGET: begin
            corr_nxt = frac_r - last_raw_r;
            mode_lim = TRIM_LIMIT;
         end
         default: begin
            corr_nxt = -last_raw_r;
            mode_lim = NULL_LIMIT;
         end
      endcase
   end

   // Step against the present correction, deviation against factory zero
   assign step = corr_nxt - corr_r;
   assign dev = corr_nxt;
   // Accumulated limit is tested on the drift total after this step
   // A refused request adds nothing to drift, so a smaller step may follow
   assign accept = zero_enabled
      && (step < STEP_LIMIT) && (step > -STEP_LIMIT)
      && (drift_r + 32'(step < 0 ? -step : step) < 32'(ACC_LIMIT))
      && (dev <= mode_lim) && (dev >= -mode_lim);

   // Zero engine; refused requests leave the correction untouched
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         corr_r <= 24'sh0;
         drift_r <= 32'sh0;
         zero_done <= 1'b0;
         zero_rejected <= 1'b0;
      end else begin
         zero_done <= req && accept;
         zero_rejected <= req && !accept;
         if (req && accept) begin
            corr_r <= corr_nxt;
            // Drift only accumulates; no port can clear it
            drift_r <= drift_r + 32'(step < 0 ? -step : step);
         end
      end
   end
   assign zero_correction = corr_r;
   assign drift_total = drift_r;

   // Same correction feeds both outputs
   assign corrected = raw_pressure + corr_r;

   // Digital and analog outputs; analog keeps 10 V at full range
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         digital_pressure <= 24'sh0;
         analog_code <= 16'h0;
      end else if (sample_valid) begin
         digital_pressure <= corrected;
         if (corrected <= 24'sh0) begin
            analog_code <= 16'h0;
         end else if (corrected >= FULL_RANGE) begin
            // Over-range beyond 10 V is clipped at full code
            analog_code <= DAC_FULL;
         end else begin
            analog_code <= 16'((40'(corrected) * 40'(DAC_FULL)) / 40'(FULL_RANGE));
         end
      end
   end

   // Powered-on seconds; only power loss resets it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sec_r <= 40'h0;
         on_r <= 32'h0;
      end else if (tick) begin
         sec_r <= 40'h0;
         on_r <= on_r + 32'h1;
      end else begin
         sec_r <= sec_r + 40'h1;
      end
   end
   assign tick = (sec_r == 40'(SEC_CYCLES - 1));
   assign on_time = on_r;

   // Event counters count entry into each condition once
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         over_d_r <= 1'b0;
         short_d_r <= 1'b0;
         over_range_count <= '0;
         short_count <= '0;
      end else begin
         short_d_r <= short_r;
         if (short_r && !short_d_r) begin
            short_count <= short_count + 1'b1;
         end
         if (sample_valid) begin
            over_d_r <= raw_pressure > OVER_LIMIT;
            if (raw_pressure > OVER_LIMIT && !over_d_r) begin
               over_range_count <= over_range_count + 1'b1;
            end
         end
      end
   end

   // Extreme trackers; after a clear the next sample seeds both
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_valid_r <= 1'b0;
         pressure_max <= 24'sh0;
         pressure_min <= 24'sh0;
         max_time <= 32'h0;
         min_time <= 32'h0;
      end else if (extremes_clear) begin
         ext_valid_r <= 1'b0;
      end else if (sample_valid) begin
         ext_valid_r <= 1'b1;
         if (!ext_valid_r || corrected > pressure_max) begin
            pressure_max <= corrected;
            max_time <= on_r;
         end
         if (!ext_valid_r || corrected < pressure_min) begin
            pressure_min <= corrected;
            min_time <= on_r;
         end
      end
   end

   // Limit alarm; indicator goes amber with it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alarm <= 1'b0;
      end else if (sample_valid) begin
         alarm <= (corrected > upper_limit) || (corrected < lower_limit);
      end
   end
   assign led_amber = alarm;

   // Display refresh; period zero leaves only manual refreshes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ref_cnt_r <= 16'h0;
         display_update <= 1'b0;
      end else begin
         display_update <= manual_refresh;
         if (refresh_rate == 16'h0) begin
            ref_cnt_r <= 16'h0;
         end else if (tick) begin
            if (ref_cnt_r >= refresh_rate - 16'h1) begin
               ref_cnt_r <= 16'h0;
               display_update <= 1'b1;
            end else begin
               ref_cnt_r <= ref_cnt_r + 16'h1;
            end
         end
      end
   end
endmodule : zcd_top
`default_nettype wire

// ==== testbench/zcd_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// Port watcher for the zero and diagnostics block
module zcd_checker import zcd_pkg::*; #(
   parameter int CNT_W = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic signed [23:0] raw_pressure,
   input wire logic sample_valid,
   input wire logic temp_ready_pin,
   input wire logic diaphragm_short_pin,
   input wire logic remote_zero,
   input wire logic extremes_clear,
   input wire logic [15:0] refresh_rate,
   input wire logic manual_refresh,
   input wire logic standby,
   input wire logic zero_enabled,
   input wire logic zero_done,
   input wire logic zero_rejected,
   input wire logic signed [23:0] zero_correction,
   input wire logic signed [31:0] drift_total,
   input wire logic [31:0] on_time,
   input wire logic [CNT_W-1:0] over_range_count,
   input wire logic [CNT_W-1:0] short_count,
   input wire logic signed [23:0] pressure_max,
   input wire logic signed [23:0] pressure_min,
   input wire logic alarm,
   input wire logic led_amber,
   input wire logic display_update
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // Short pin held long enough that its one entry is already counted
   sequence s_short_held;
      diaphragm_short_pin [*8];
   endsequence
   // Clear, one idle cycle, then the first sample
   sequence s_clear_seed;
      extremes_clear ##1 !sample_valid ##1 (sample_valid && !extremes_clear);
   endsequence
   AST_COLD_NO_ZERO: assert property (!zero_enabled |=> !zero_done)
      else $error("zero applied while zero actions are disabled");
   AST_STANDBY_CLEAR: assert property (temp_ready_pin [*6] |-> !standby)
      else $error("standby still shown at control temperature");
   AST_REMOTE_ANSWER: assert property (remote_zero |=> zero_done ^ zero_rejected)
      else $error("remote zero got no single answer");
   AST_STEP_BOUND: assert property (zero_done |->
      (zero_correction - $past(zero_correction)) < STEP_LIMIT &&
      ($past(zero_correction) - zero_correction) < STEP_LIMIT)
      else $error("accepted zero step too large");
   AST_REJECT_KEEPS: assert property (zero_rejected |->
      $stable(zero_correction) && $stable(drift_total) && drift_total < ACC_LIMIT)
      else $error("refused zero changed the correction");
   AST_ON_TIME_STEP: assert property (on_time == $past(on_time) ||
      on_time == $past(on_time) + 32'h1)
      else $error("on time jumped or fell");
   AST_OVER_ENTRY: assert property (
      over_range_count != $past(over_range_count) |->
      $past(sample_valid) && $past(raw_pressure) > OVER_LIMIT &&
      over_range_count == $past(over_range_count) + 1'b1)
      else $error("over-range count moved without an over-range sample");
   AST_SHORT_ONCE: assert property (s_short_held |=> $stable(short_count))
      else $error("short count moved while the short persisted");
   AST_AMBER: assert property (led_amber == alarm)
      else $error("amber indicator differs from alarm");
   AST_REFRESH_OFF: assert property (refresh_rate == 16'h0 &&
      $past(refresh_rate) == 16'h0 && !$past(manual_refresh) |-> !display_update)
      else $error("display refreshed with automatic updates off");
   AST_CLEAR_SEED: assert property (s_clear_seed |=> pressure_max == pressure_min)
      else $error("extremes not seeded by the first sample after clear");
endmodule : zcd_checker
bind zcd_top zcd_checker #(.CNT_W(CNT_W)) u_zcd_checker (
   .ref_clk, .rst, .raw_pressure, .sample_valid, .temp_ready_pin, .diaphragm_short_pin,
   .remote_zero, .extremes_clear, .refresh_rate, .manual_refresh, .standby, .zero_enabled,
   .zero_done, .zero_rejected, .zero_correction, .drift_total, .on_time, .over_range_count,
   .short_count, .pressure_max, .pressure_min, .alarm, .led_amber, .display_update
);
`default_nettype wire

// ==== testbench/zcd_operator_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Operator button and network host; button line is low when released
module zcd_operator_model (
   input wire logic ref_clk,
   output logic button_pin,
   output logic remote_zero,
   output logic net_cfg_write,
   output logic [1:0] net_mode,
   output logic signed [23:0] net_fraction
);
   // Idle levels from time zero
   initial begin
      button_pin = 1'b0;
      remote_zero = 1'b0;
      net_cfg_write = 1'b0;
      net_mode = 2'h0;
      net_fraction = 24'sh0;
   end
   // Holds the button for n cycles
   task automatic press(input int n);
      @(posedge ref_clk);
      #1 button_pin = 1'b1;
      repeat (n) @(posedge ref_clk);
      #1 button_pin = 1'b0;
   endtask : press
   // One-cycle network zero command
   task automatic zero_cmd();
      @(posedge ref_clk);
      #1 remote_zero = 1'b1;
      @(posedge ref_clk);
      #1 remote_zero = 1'b0;
   endtask : zero_cmd
   // Mode applied first, values applied second, before any zero
   task automatic configure(input logic [1:0] mode, input logic signed [23:0] frac);
      @(posedge ref_clk);
      #1 net_mode = mode;
      net_cfg_write = 1'b1;
      @(posedge ref_clk);
      #1 net_fraction = frac;
      @(posedge ref_clk);
      #1 net_cfg_write = 1'b0;
   endtask : configure
endmodule : zcd_operator_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top import zcd_pkg::*;;
   localparam int HOLD = 20;
   typedef struct {logic ok; logic signed [23:0] corr;} zcd_note_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic signed [23:0] raw_pressure = 24'sh0;
   logic sample_valid = 1'b0;
   logic temp_ready_pin = 1'b0;
   logic diaphragm_short_pin = 1'b0;
   logic extremes_clear = 1'b0;
   logic manual_refresh = 1'b0;
   logic [15:0] refresh_rate = 16'h1;
   logic signed [23:0] upper_limit = 24'sh7fffff;
   logic signed [23:0] lower_limit = 24'sh800000;
   logic button_pin, remote_zero, net_cfg_write;
   logic [1:0] net_mode, active_mode;
   logic signed [23:0] net_fraction, digital_pressure, zero_correction, pressure_max, pressure_min;
   logic [15:0] analog_code;
   logic standby, zero_enabled, zero_done, zero_rejected, alarm, led_amber, display_update;
   logic signed [31:0] drift_total;
   logic [31:0] on_time, max_time, min_time, over_range_count, short_count, ovc, t0;
   int checks = 0;
   int miscompares = 0;
   int i, k;
   logic over_prev;
   logic signed [23:0] cur = 24'sh0, v, d, mx, mn;
   zcd_note_t notes[$];
   zcd_note_t n;
   // Mode table: offset, target, code 3 as nulling, nulling
   logic [1:0] md [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
   logic signed [23:0] fr [6] = '{24'sh190, 24'sh1f4, 24'sh1f4, 24'sh1f4, 24'sh0, 24'sh0};
   logic signed [23:0] rw [6] = '{24'sh64, -24'sh64, 24'sh0, -24'sh64, 24'sh12c, -24'sh64};
   logic ok [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   // Short counts keep the run small
   zcd_top #(.WARM_CYCLES(100), .HOLD_CYCLES(HOLD), .SEC_CYCLES(10), .CNT_W(32)) u_zcd_top (
      .ref_clk, .rst, .raw_pressure, .sample_valid, .temp_ready_pin, .diaphragm_short_pin,
      .button_pin, .remote_zero, .net_cfg_write, .net_mode, .net_fraction, .upper_limit,
      .lower_limit, .extremes_clear, .refresh_rate, .manual_refresh, .digital_pressure,
      .analog_code, .standby, .zero_enabled, .zero_done, .zero_rejected, .active_mode,
      .zero_correction, .drift_total, .on_time, .over_range_count, .short_count,
      .pressure_max, .max_time, .pressure_min, .min_time, .alarm, .led_amber, .display_update
   );
   zcd_operator_model u_zcd_operator_model (
      .ref_clk, .button_pin, .remote_zero, .net_cfg_write, .net_mode, .net_fraction
   );
   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;
   // Compares one value exactly; an x matches only an x
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic sample(input logic signed [23:0] s);
      tick(1);
      raw_pressure = s;
      sample_valid = 1'b1;
      tick(1);
      sample_valid = 1'b0;
   endtask : sample
   // Notes the expected answer, then fires from button or network
   task automatic zero(input logic good, input logic signed [23:0] corr, input logic btn);
      notes.push_back('{good, good ? corr : cur});
      if (good) cur = corr;
      if (btn) u_zcd_operator_model.press(HOLD * 3);
      else u_zcd_operator_model.zero_cmd();
      tick(4);
   endtask : zero
   // Pairs each zero answer with the oldest note; an unasked answer is a fault
   always @(posedge ref_clk) begin
      #2;
      if (zero_done === 1'b1 || zero_rejected === 1'b1) begin
         if (notes.size() == 0) check("unrequested zero answer", 1'b1, 1'b0);
         else begin
            n = notes.pop_front();
            check("zero accepted", zero_done, n.ok);
            check("zero correction", zero_correction, n.corr);
         end
      end
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(47));
      tick(5);
      rst = 1'b0;
      check("standby", standby, 1'b1);
      zero(1'b0, 24'sh0, 1'b0);
      temp_ready_pin = 1'b1;
      tick(8);
      check("standby", standby, 1'b0);
      zero(1'b0, 24'sh0, 1'b0);
      for (i = 0; i < 400 && zero_enabled !== 1'b1; i++) tick(1);
      $display("test warm-up done");
      // Gauge at vacuum shows a drifted reading
      sample(24'sh12c);
      zero(1'b1, -24'sh12c, 1'b0);
      sample(24'sh12c);
      check("digital", digital_pressure, 24'sh0);
      sample(24'sh283c);
      check("analog", analog_code, DAC_FULL);
      $display("test remote null done");
      sample(-24'shc8);
      u_zcd_operator_model.press(HOLD - 4);
      tick(10);
      zero(1'b1, 24'shc8, 1'b1);
      sample(-24'sh514);
      zero(1'b0, 24'sh0, 1'b0);
      $display("test button done");
      for (i = 0; i < 6; i++) begin
         u_zcd_operator_model.configure(md[i], fr[i]);
         check("mode", active_mode, md[i] == 2'h3 ? 2'h0 : md[i]);
         sample(rw[i]);
         zero(ok[i], fr[i] - rw[i], 1'b0);
         if (ok[i]) begin
            sample(rw[i]);
            check("digital", digital_pressure, fr[i]);
            check("analog", analog_code, 16'(fr[i] * 32 / 5));
         end
      end
      check("drift", drift_total, 32'h76c);
      $display("test modes done");
      upper_limit = 24'sh2328;
      lower_limit = -24'sh1f4;
      t0 = on_time;
      ovc = over_range_count;
      over_prev = 1'b0;
      extremes_clear = 1'b1;
      tick(1);
      extremes_clear = 1'b0;
      for (i = 0; i < 80; i++) begin
         v = 24'($urandom_range(12500)) - 24'sh3e8;
         sample(v);
         d = v + cur;
         if (i == 0 || d > mx) mx = d;
         if (i == 0 || d < mn) mn = d;
         if (v > OVER_LIMIT && !over_prev) ovc++;
         over_prev = v > OVER_LIMIT;
         check("alarm", alarm, d > upper_limit || d < lower_limit);
      end
      check("max", pressure_max, mx);
      check("min", pressure_min, mn);
      check("stamps", max_time <= on_time && min_time <= on_time, 1'b1);
      check("on time kept", on_time >= t0, 1'b1);
      check("over count", over_range_count, ovc);
      $display("test extremes done");
      for (i = 0; i < 4; i++) begin
         diaphragm_short_pin = ~diaphragm_short_pin;
         tick(12);
      end
      check("short count", short_count, 32'h2);
      refresh_rate = 16'h0;
      tick(25);
      k = 0;
      for (i = 0; i < 60; i++) begin
         manual_refresh = (i == 10);
         tick(1);
         if (display_update === 1'b1) k++;
      end
      check("display updates", k, 1);
      $display("test counters and display done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
